/* File: src/pwmc_cfg.svh */
// Timing, scaling and reset constants for the current mode pulse width controller
`ifndef PWMC_CFG_SVH
`define PWMC_CFG_SVH
// ----------------------------------------
// Clock and switching timing (ns)
// ----------------------------------------
`define PWMC_CLK_NS 25
`define PWMC_PERIOD_NS 10000
`define PWMC_MIN_OFF_NS 156
`define PWMC_BLANK_NORM_NS 220
`define PWMC_BLANK_BURST_NS 180
`define PWMC_SS_STEP_NS 300000
`define PWMC_SS_TOTAL_NS 10000000
`define PWMC_JIT_PERIOD_NS 4000000
// ----------------------------------------
// Ratios and scaling
// ----------------------------------------
`define PWMC_JIT_DEV_PCT 4
`define PWMC_DMAX_NUM 3
`define PWMC_DMAX_DEN 4
`define PWMC_GAIN_NUM 13
`define PWMC_GAIN_SHIFT 2
`define PWMC_SS_STEPS 32
`define PWMC_SS_LEVEL_SHIFT 9
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PWMC_RST_STEP 5'h00
`define PWMC_RST_JIT 6'h00
`define PWMC_RST_BLANK 4'h0
`endif

/* File: src/pwmc_pkg.sv */
// Types shared by the current mode pulse width controller
package pwmc_pkg;
  // ----------------------------------------
  // Operating states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PWMC_OFF  = 2'b00,
    PWMC_SOFT = 2'b01,
    PWMC_NORM = 2'b10
  } pwmc_state_t;
  // ----------------------------------------
  // Sampled analog levels, same clock as the block
  // ----------------------------------------
  typedef struct packed {
    logic [11:0] sense;
    logic [11:0] feedback;
    logic [11:0] peak_th;
    logic [11:0] burst_th;
  } pwmc_sense_t;
  // ----------------------------------------
  // Supply and mode pins, asynchronous
  // ----------------------------------------
  typedef struct packed {
    logic above_on;
    logic below_off;
    logic burst;
    logic restart;
  } pwmc_pins_t;
endpackage

/* File: src/pwmc_top.sv */
// Current mode pulse width controller with soft start, jitter and current limits
// How it works
// - Sense scaled by 3.25 before comparing with feedback and soft start level
// - Amplified current above feedback ends pulse
// - Soft start begins at turn-on threshold
// - Step counter raises soft start level
// - Sink switched off after 10 ms
// - Duty rises from zero to maximum
// - Every auto restart reruns soft start
// - 100 kHz, swept four percent, 4 ms
// - Jitter only in normal operation
// - On portion capped at 300 clocks, 0.75 of the nominal period
// - Latch set by oscillator, cleared by trips
// - Latch reset turns gate off at once
// - Gate low while supply in lockout
// - Peak limit trip clears latch each cycle
// - Blanking feeds peak, burst and amplifier
// - Blanking 220 ns normal, 180 ns burst
// - Burst limit active only in burst
// - Low supply clears soft start counter
// - Minimum 156 ns off after trigger
`timescale 1ns/100ps
`include "pwmc_cfg.svh"
module pwmc_top #(
  parameter int SS_STEP_CYC = `PWMC_SS_STEP_NS / `PWMC_CLK_NS,
  parameter int SS_TOTAL_CYC = `PWMC_SS_TOTAL_NS / `PWMC_CLK_NS,
  parameter int JIT_STEP_CYC = (`PWMC_JIT_PERIOD_NS / `PWMC_CLK_NS) /
                               (4 * ((`PWMC_PERIOD_NS / `PWMC_CLK_NS) * `PWMC_JIT_DEV_PCT / 100))
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Supply, burst and restart pins
  input wire pwmc_pkg::pwmc_pins_t PINS,
  // Sampled sense and feedback levels
  input wire pwmc_pkg::pwmc_sense_t LEVELS,
  // Gate drive and status
  output logic GATE_DRIVE,
  output logic SINK_ON,
  output logic NORMAL_MODE,
  output logic [4:0] SOFTSTART_STEP
);
  import pwmc_pkg::*;

  // ----------------------------------------
  // Derived cycle counts
  // ----------------------------------------
  localparam int PERIOD_CYC = `PWMC_PERIOD_NS / `PWMC_CLK_NS;
  localparam int MAX_ON_CYC = PERIOD_CYC * `PWMC_DMAX_NUM / `PWMC_DMAX_DEN;
  localparam int MIN_OFF_CYC = (`PWMC_MIN_OFF_NS + `PWMC_CLK_NS - 1) / `PWMC_CLK_NS;
  localparam int BLANK_N_CYC = (`PWMC_BLANK_NORM_NS + `PWMC_CLK_NS - 1) / `PWMC_CLK_NS;
  localparam int BLANK_B_CYC = (`PWMC_BLANK_BURST_NS + `PWMC_CLK_NS - 1) / `PWMC_CLK_NS;
  localparam int JIT_DEV_CYC = PERIOD_CYC * `PWMC_JIT_DEV_PCT / 100;

  // Saturating count-done test used by the soft start tick, soft start total and jitter step counters
  function automatic logic reached(input logic [19:0] cnt, input int lim);
    reached = (32'(cnt) >= 32'(lim - 1));
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic restart_dly_q;
  // Two flops per asynchronous pin, third flop only for the restart edge
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      restart_dly_q <= 1'b0;
    end else begin
      sync1_q <= PINS;
      sync2_q <= sync1_q;
      restart_dly_q <= sync2_q[0];
    end
  end
  wire vcc_on_s = sync2_q[3];
  wire vcc_low_s = sync2_q[2];
  wire burst_s = sync2_q[1];
  wire restart_p = sync2_q[0] & ~restart_dly_q;

  // ----------------------------------------
  // Operating state and soft start counters
  // ----------------------------------------
  pwmc_state_t state_q, state_d;
  logic [19:0] ss_tick_q;
  logic [19:0] ss_total_q;
  logic [4:0] step_q;
  wire ss_done = reached(ss_total_q, SS_TOTAL_CYC);
  wire ss_tick = reached(ss_tick_q, SS_STEP_CYC);
  // Lockout wins over everything; a restart attempt re-enters soft start
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PWMC_OFF: if (vcc_on_s && !vcc_low_s) state_d = PWMC_SOFT;
      PWMC_SOFT: if (vcc_low_s) state_d = PWMC_OFF;
        else if (restart_p) state_d = PWMC_SOFT;
        else if (ss_done) state_d = PWMC_NORM;
      PWMC_NORM: if (vcc_low_s) state_d = PWMC_OFF;
        else if (restart_p) state_d = PWMC_SOFT;
      default: state_d = PWMC_OFF;
    endcase
  end
  wire ss_clear = (state_d == PWMC_OFF) || restart_p || (state_q == PWMC_OFF);
  wire [19:0] ss_tick_d = (ss_clear || ss_tick) ? 20'h00000 : ss_tick_q + 20'h00001;
  wire [19:0] ss_total_d = (ss_clear || ss_done) ? ss_total_q & {20{~ss_clear}} : ss_total_q + 20'h00001;
  wire step_inc = ss_tick && (step_q != 5'(`PWMC_SS_STEPS - 1));
  wire [4:0] step_d = ss_clear ? `PWMC_RST_STEP : (step_inc ? step_q + 5'h01 : step_q);
  // Total and step counters stop at their ends, tick counter wraps; sink released when normal operation begins
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_q <= PWMC_OFF;
      ss_tick_q <= 20'h00000;
      ss_total_q <= 20'h00000;
      step_q <= `PWMC_RST_STEP;
      SINK_ON <= 1'b0;
      NORMAL_MODE <= 1'b0;
    end else begin
      state_q <= state_d;
      ss_tick_q <= ss_tick_d;
      ss_total_q <= ss_total_d;
      step_q <= step_d;
      SINK_ON <= (state_d == PWMC_SOFT);
      NORMAL_MODE <= (state_d == PWMC_NORM);
    end
  end
  assign SOFTSTART_STEP = step_q;

  // ----------------------------------------
  // Jittered oscillator
  // ----------------------------------------
  logic [9:0] phase_q;
  logic [15:0] jit_cnt_q;
  logic signed [5:0] jit_q;
  logic jit_up_q;
  // Triangle sweep of the period; held at nominal outside normal operation
  wire jit_run = (state_d == PWMC_NORM);
  wire jit_tick = reached({4'h0, jit_cnt_q}, JIT_STEP_CYC);
  wire jit_top = (jit_q == 6'(JIT_DEV_CYC));
  wire jit_bot = (jit_q == -6'(JIT_DEV_CYC));
  wire jit_up_d = !jit_run ? 1'b1 : ((jit_tick && (jit_top || jit_bot)) ? ~jit_up_q : jit_up_q);
  wire signed [5:0] jit_d = !jit_run ? `PWMC_RST_JIT :
                            (jit_tick ? (jit_up_d ? jit_q + 6'sd1 : jit_q - 6'sd1) : jit_q);
  wire [9:0] period_end = 10'(PERIOD_CYC - 1) + {{4{jit_q[5]}}, jit_q};
  wire osc_wrap = (phase_q >= period_end);
  wire [9:0] phase_d = osc_wrap ? 10'h000 : phase_q + 10'h001;
  wire osc_pulse = (phase_q == 10'h000);
  // Free-running phase; set pulse at phase zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      phase_q <= 10'h000;
      jit_cnt_q <= 16'h0000;
      jit_q <= `PWMC_RST_JIT;
      jit_up_q <= 1'b1;
    end else begin
      phase_q <= phase_d;
      jit_cnt_q <= (!jit_run || jit_tick) ? 16'h0000 : jit_cnt_q + 16'h0001;
      jit_q <= jit_d;
      jit_up_q <= jit_up_d;
    end
  end

  // ----------------------------------------
  // Blanking, amplifier and comparators
  // ----------------------------------------
  logic [3:0] blank_q;
  logic latch_q;
  logic gate_q;
  wire sense_valid = gate_q && (blank_q == 4'h0);
  wire [11:0] blanked = sense_valid ? LEVELS.sense : 12'h000;
  wire [15:0] amp_prod = {4'h0, blanked} * 16'(`PWMC_GAIN_NUM);
  wire [13:0] amp = amp_prod[15:`PWMC_GAIN_SHIFT];
  wire [13:0] ss_level = 14'({step_q, 9'h000} >> (9 - `PWMC_SS_LEVEL_SHIFT));
  wire trip_fb = sense_valid && (amp > {2'b00, LEVELS.feedback});
  wire trip_ss = sense_valid && (state_q == PWMC_SOFT) && (amp > ss_level);
  wire trip_peak = sense_valid && (blanked > LEVELS.peak_th);
  wire trip_burst = sense_valid && burst_s && (blanked > LEVELS.burst_th);
  wire trip_dmax = (phase_q >= 10'(MAX_ON_CYC - 1));
  wire trip_any = trip_fb || trip_ss || trip_peak || trip_burst || trip_dmax;
  wire run = (state_q != PWMC_OFF) && !vcc_low_s;
  wire latch_d = run && ((osc_pulse && !trip_dmax) || (latch_q && !trip_any));
  wire gate_d = latch_d && (phase_q >= 10'(MIN_OFF_CYC));
  wire gate_rise = gate_d && !gate_q;
  wire [3:0] blank_load = burst_s ? 4'(BLANK_B_CYC) : 4'(BLANK_N_CYC);
  wire [3:0] blank_d = gate_rise ? blank_load : ((blank_q != 4'h0) ? blank_q - 4'h1 : blank_q);
  // Gate follows the latch in the same edge so a trip shows with no extra cycle
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      blank_q <= `PWMC_RST_BLANK;
      latch_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      blank_q <= blank_d;
      latch_q <= latch_d;
      gate_q <= gate_d;
    end
  end
  assign GATE_DRIVE = gate_q;

  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  AST_GATE_LOCKOUT: assert property (vcc_low_s |-> ##2 !GATE_DRIVE)
    else $error("gate on during supply lockout");
  AST_DMAX_CAP: assert property (phase_q >= 10'(MAX_ON_CYC) |-> !gate_q)
    else $error("gate on beyond maximum duty");
  AST_DMAX_CLEAR: assert property (latch_q && trip_dmax |=> !latch_q && !gate_q)
    else $error("latch not cleared at duty end");
  AST_MIN_OFF: assert property (phase_q <= 10'(MIN_OFF_CYC) |-> !gate_q)
    else $error("gate on inside minimum off delay");
  AST_FB_TRIP: assert property (trip_fb |=> !gate_q && !latch_q)
    else $error("feedback trip did not end pulse");
  AST_PEAK_TRIP: assert property (trip_peak |=> !GATE_DRIVE)
    else $error("peak trip did not end pulse");
  AST_BURST_ONLY: assert property (trip_burst |-> burst_s ##1 !gate_q)
    else $error("burst limit acted outside burst mode");
  AST_BLANK_NORM: assert property ($rose(gate_q) && !$past(burst_s) |-> !sense_valid [*8])
    else $error("sense seen inside blanking");
  AST_RESTART_SS: assert property (restart_p && state_q != PWMC_OFF && !vcc_low_s
    |=> state_q == PWMC_SOFT && step_q == 5'h00)
    else $error("restart did not rerun soft start");
  AST_JIT_FIXED: assert property (state_q != PWMC_NORM |-> jit_q == 6'sd0)
    else $error("jitter active outside normal operation");
  AST_STEP_MONO: assert property ($changed(step_q) |-> step_q == $past(step_q) + 5'h01 || step_q == 5'h00)
    else $error("soft start step jumped");
  AST_OFF_CLEAR: assert property (state_q == PWMC_OFF |-> step_q == 5'h00 && !SINK_ON)
    else $error("soft start counter not cleared in lockout");


  // ----------------------------------------
  // Per-rule checks on comparators, counters and oscillator
  // ----------------------------------------
  AST_AMP_GAIN: assert property (sense_valid && LEVELS.sense == 12'h064
    |-> amp == 14'h145)
    else $error("sense gain wrong");
  AST_AMP_FB: assert property (sense_valid && amp > {2'b00, LEVELS.feedback}
    |=> !GATE_DRIVE)
    else $error("amplified current above feedback left gate on");
  AST_SOFT_ENTRY: assert property (state_q == PWMC_OFF && vcc_on_s && !vcc_low_s
    |=> SINK_ON && state_q == PWMC_SOFT)
    else $error("soft start not begun at turn-on");
  AST_STEP_HOLD: assert property (!ss_tick && !ss_clear
    |=> $stable(step_q))
    else $error("soft start step moved between ticks");
  AST_STEP_TICK: assert property (ss_tick && !ss_clear && step_q != 5'h1f
    |=> step_q == $past(step_q) + 5'h01)
    else $error("soft start step missed a tick");
  AST_SS_DONE: assert property (state_q == PWMC_SOFT && ss_done && !vcc_low_s && !restart_p
    |=> NORMAL_MODE && !SINK_ON)
    else $error("soft start did not finish");
  AST_SINK_NORM: assert property (NORMAL_MODE
    |-> !SINK_ON)
    else $error("sink on in normal operation");
  AST_SS_ZERO: assert property (state_q == PWMC_SOFT && step_q == 5'h00 && sense_valid && LEVELS.sense != 12'h000
    |=> !gate_q)
    else $error("zero soft start level let pulse run");
  AST_RESTART_NORM: assert property (state_q == PWMC_NORM && restart_p && !vcc_low_s
    |=> SINK_ON && !NORMAL_MODE)
    else $error("restart from normal did not reenter soft start");
  AST_JIT_RANGE: assert property (1'b1
    |-> int'(jit_q) <= JIT_DEV_CYC && int'(jit_q) >= -JIT_DEV_CYC)
    else $error("jitter beyond deviation");
  AST_JIT_SLEW: assert property (state_q == PWMC_NORM && $past(state_q) == PWMC_NORM && $changed(jit_q)
    |-> $past(jit_tick))
    else $error("jitter moved off its step");
  AST_PERIOD_FIX: assert property (state_q != PWMC_NORM
    |-> period_end == 10'(PERIOD_CYC - 1))
    else $error("period not nominal outside normal operation");
  AST_LATCH_SET: assert property (run && osc_pulse
    |=> latch_q)
    else $error("oscillator pulse did not set latch");
  AST_LATCH_TRIP: assert property (latch_q && trip_any && !osc_pulse
    |=> !latch_q)
    else $error("trip did not clear latch");
  AST_LATCH_GATE: assert property (!latch_q
    |-> !gate_q)
    else $error("gate on with latch reset");
  AST_RUN_GATE: assert property (!run
    |=> !gate_q)
    else $error("gate on while not running");
  AST_PEAK_LATCH: assert property (trip_peak
    |=> !latch_q)
    else $error("peak trip did not clear latch");
  AST_BLANK_MASK: assert property (blank_q != 4'h0
    |-> !trip_fb && !trip_ss && !trip_peak && !trip_burst)
    else $error("trip inside blanking");
  AST_BLANK_BURST: assert property ($rose(gate_q) && $past(burst_s)
    |-> !sense_valid [*8])
    else $error("sense seen inside burst blanking");
  AST_BLANK_END: assert property ($rose(gate_q) && !$past(burst_s)
    |-> ##9 (sense_valid || !gate_q))
    else $error("blanking longer than normal interval");
  AST_BURST_GATE: assert property (!burst_s
    |-> !trip_burst)
    else $error("burst limit active outside burst");
  AST_OFF_STEP: assert property (vcc_low_s
    |=> step_q == 5'h00)
    else $error("low supply left soft start step");
  AST_MIN_OFF_SET: assert property (osc_pulse
    |=> !gate_q)
    else $error("gate on right after trigger");
  AST_DMAX_LATCH: assert property (phase_q >= 10'(MAX_ON_CYC)
    |-> !latch_q)
    else $error("latch set beyond maximum duty");

  COV_NORMAL: cover property (state_q == PWMC_SOFT ##1 state_q == PWMC_NORM);
  COV_GATE_NORM: cover property (state_q == PWMC_NORM && $rose(gate_q));
  COV_BURST_TRIP: cover property (trip_burst ##1 !gate_q);
  COV_RESTART: cover property (state_q == PWMC_NORM && restart_p);
  COV_BURST_BLANK: cover property ($rose(gate_q) && burst_s);
endmodule

/* File: test/current_mode_pwm_softstart_bench.sv */
// Self-checking bench for the current mode pulse width controller
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module current_mode_pwm_softstart_bench;
  import pwmc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  pwmc_pins_t pins = '0;
  pwmc_sense_t levels;
  logic [11:0] on_level = 12'h000;
  logic [11:0] fb = 12'hfff;
  logic [11:0] pk = 12'hfff;
  logic [11:0] bt = 12'hfff;
  logic [11:0] sense_w;
  logic gate, sink, norm;
  logic [4:0] step;
  int fail_count = 0;
  int comparisons = 0;
  assign levels = {sense_w, fb, pk, bt};
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  // Shortened soft start counts keep the run small
  pwmc_top #(.SS_STEP_CYC(40), .SS_TOTAL_CYC(1400), .JIT_STEP_CYC(4)) dut_u (
    .SYS_CLK(sys_clk), .RESET(reset), .PINS(pins), .LEVELS(levels),
    .GATE_DRIVE(gate), .SINK_ON(sink), .NORMAL_MODE(norm), .SOFTSTART_STEP(step));
  pwmc_switch_model sw_u (.clk(sys_clk), .gate(gate), .on_level(on_level), .sense(sense_w));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  // Inputs always change a fixed 1 ns after the rising edge
  task automatic cyc();
    @(posedge sys_clk);
    #1;
  endtask
  // Skip any pulse in progress, then measure gap and width of the next one
  task automatic pulse(output int gap, output int w);
    int n;
    n = 0;
    gap = 0;
    w = 0;
    while (gate === 1'b1 && n < 600) begin cyc(); n++; end
    while (gate !== 1'b1 && gap < 1000) begin cyc(); gap++; end
    while (gate === 1'b1 && w < 600) begin cyc(); w++; end
  endtask
  task automatic final_report();
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Supply held in lockout: nothing may switch even with the on level seen
  task automatic t_lockout();
    `CHK({gate, sink, norm, step}, 8'h00)
    pins.above_on = 1'b1;
    pins.below_off = 1'b1;
    on_level = 12'hfff;
    repeat (30) cyc();
    `CHK({gate, sink}, 2'b00)
  endtask
  // Leaving lockout starts soft start; first pulses are cut by the soft start level
  task automatic t_softstart();
    int n, g, w1, w2, v;
    n = 0;
    pins.below_off = 1'b0;
    while (sink !== 1'b1 && n < 10) begin cyc(); n++; end
    `CHK({sink, norm}, 2'b10)
    pulse(g, w1);
    `CHK(w1, 10)
    pulse(g, w2);
    `CHK(w1 + g, 400)
    v = step;
    n = 0;
    while (step === v[4:0] && n < 60) begin cyc(); n++; end
    v = step;
    n = 0;
    while (step === v[4:0] && n < 60) begin cyc(); n++; end
    `CHK(n, 40)
    `CHK(step, v[4:0] + 5'h01)
    n = 0;
    while (norm !== 1'b1 && n < 1000) begin cyc(); n++; end
    `CHK({norm, sink, step}, 7'h5f)
  endtask
  // One pulse under given limits; sense of 100 amplifies to 325
  task automatic duty_case(input logic brst, input logic [11:0] p, b, f, input int exp_w);
    int g, w;
    on_level = 12'h064;
    pins.burst = brst;
    pk = p;
    bt = b;
    fb = f;
    pulse(g, w);
    pulse(g, w);
    `CHK(w, exp_w)
  endtask
  // Auto restart reruns soft start from zero; lockout clears it and kills the gate
  task automatic t_restart();
    int n;
    n = 0;
    pins.restart = 1'b1;
    while (sink !== 1'b1 && n < 10) begin cyc(); n++; end
    pins.restart = 1'b0;
    `CHK({sink, norm, step}, 7'h40)
    repeat (100) cyc();
    pins.below_off = 1'b1;
    repeat (6) cyc();
    `CHK({gate, sink, norm, step}, 8'h00)
    repeat (400) cyc();
    `CHK(gate, 1'b0)
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) cyc();
    reset = 1'b0;
    cyc();
    t_lockout();
    t_softstart();
    duty_case(1'b0, 12'hfff, 12'hfff, 12'h145, 292);
    duty_case(1'b0, 12'hfff, 12'hfff, 12'h144, 10);
    duty_case(1'b0, 12'h063, 12'hfff, 12'hfff, 10);
    duty_case(1'b0, 12'h064, 12'hfff, 12'hfff, 292);
    duty_case(1'b1, 12'hfff, 12'h063, 12'hfff, 9);
    duty_case(1'b0, 12'hfff, 12'h063, 12'hfff, 292);
    t_restart();
    final_report();
  end
  // Whole run needs under 10000 cycles; twice that means a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end
endmodule

/* File: test/pwmc_switch_model.sv */
// Behavioural power switch, sense resistor and flat current level seen by the controller
`timescale 1ns/100ps
module pwmc_switch_model (
  // Clock
  input wire logic clk,
  // Gate from the controller and current level while the switch conducts
  input wire logic gate,
  input wire logic [11:0] on_level,
  // Sense voltage back to the controller
  output logic [11:0] sense
);
  // Current builds one clock after the switch closes and is gone one clock after it opens,
  // so a late gate fall shows up as a stale sense value
  always_ff @(posedge clk) begin
    sense <= gate ? on_level : 12'h000;
  end
endmodule
